// *** include/thse_consts.svh ***
// Notes on behaviour
// R1: Four-contact: out high when closed 0, open 1
// R2: Four-contact: all active within 0.5 s
// R3: Pattern 0,1,0,1 is the actuated condition
// R4: Pattern 1,0,1,0 is the released condition
// R5: Two-contact: out high when both inputs 1
// R6: Two-contact: other input follows within 0.5 s
// R7: No interference check, no release time limit
// R8: Two-position selector: 10 gives one, 01 two
// R9: Three-position: output one only for 100
// R10: Three-position: output two only for 010
// R11: Three-position: output three only 001, else none
// R12: After timeout hold 0 until full release
`ifndef THSE_CONSTS_SVH
`define THSE_CONSTS_SVH
// Sync time window in microseconds
`define THSE_WINDOW_US 500000
// Clock rate in MHz
`define THSE_CLK_MHZ 250
// Window length in clock cycles
`define THSE_WINDOW_CYC (`THSE_WINDOW_US * `THSE_CLK_MHZ)
// Reset value of the element outputs
`define THSE_OUT_RST 1'b0
`endif

// *** include/thse_pkg.sv ***
package thse_pkg;
  // Two-hand timer states, one-hot
  typedef enum logic [3:0] {
    THSE_IDLE = 4'b0001,
    THSE_WAIT = 4'b0010,
    THSE_ON = 4'b0100,
    THSE_FAULT = 4'b1000
  } thse_state_type;
  // Four-contact two-hand inputs
  typedef struct packed {
    logic closed_1;
    logic open_1;
    logic closed_2;
    logic open_2;
  } thse_four_type;
  // Selector outputs
  typedef struct packed {
    logic pos_1;
    logic pos_2;
    logic pos_3;
  } thse_sel_type;
endpackage : thse_pkg

// *** rtl/thse_eval.sv ***
`timescale 1ns/100ps
`include "thse_consts.svh"
// Two-hand and selector switch evaluation
module thse_eval
  import thse_pkg::*;
#(
  parameter int WINDOW_CYC = `THSE_WINDOW_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Variant select, static strap
  input wire logic two_hand_two_contact,
  // Four-contact two-hand pins
  input wire thse_four_type four_pins,
  // Two-contact two-hand pins
  input wire logic [1:0] pair_pins,
  // Two-position selector pins
  input wire logic [1:0] sel2_pins,
  // Three-position selector pins
  input wire logic [2:0] sel3_pins,
  // Outputs
  output logic two_hand_out,
  output logic [1:0] selector_two_position,
  output thse_sel_type selector_three_position
);
  // Synchronisers, first stage read only by second
  logic [10:0] sync1_ff, sync2_ff;
  logic [1:0] sel2_ff, nxt_sel2;
  thse_sel_type sel3_ff, nxt_sel3;
  logic var_meta_ff, var_ff; // Variant strap, two stages
  thse_four_type four_s;
  logic [1:0] pair_s, pair_d_ff;
  logic [3:0] four_d_ff;
  logic chg, rel, act, th_out;

  // One-hot position decode
  function automatic logic onehot_at(input logic [2:0] v, input int i);
    onehot_at = (v == (3'h1 << i));
  endfunction : onehot_at

  // Two-stage synchronisers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      // Four-contact bits rest at the released pattern, so no false change
      sync1_ff <= {4'ha, 7'h0};
      sync2_ff <= {4'ha, 7'h0};
    end else begin
      sync1_ff <= {four_pins, pair_pins, sel2_pins, sel3_pins};
      sync2_ff <= sync1_ff;
    end
  end
  assign four_s = sync2_ff[10:7];
  assign pair_s = sync2_ff[6:5];

  // Pattern decode for the timer element
  always_comb begin
    if (var_ff) begin
      rel = (pair_s == 2'h0);
      act = (pair_s == 2'h3); // R5
      chg = |(pair_s & ~pair_d_ff); // R6
    end else begin
      rel = (four_s == 4'ha); // R4
      act = (four_s == 4'h5); // R1 R3
      // Closed falling or open rising starts window
      chg = |((four_d_ff ^ four_s) & (four_s ^ 4'ha)); // R2
    end
  end

  // Selector decode
  always_comb begin
    nxt_sel2 = {sync2_ff[4:3] == 2'h2, sync2_ff[4:3] == 2'h1}; // R8
    nxt_sel3.pos_1 = onehot_at(sync2_ff[2:0], 2); // R9
    nxt_sel3.pos_2 = onehot_at(sync2_ff[2:0], 1); // R10
    nxt_sel3.pos_3 = onehot_at(sync2_ff[2:0], 0); // R11
  end

  // Registers; variant caught after reset release
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sel2_ff <= 2'h0;
      sel3_ff <= '0;
      four_d_ff <= 4'ha;
      pair_d_ff <= 2'h0;
      var_meta_ff <= 1'b0;
      var_ff <= 1'b0;
    end else begin
      sel2_ff <= nxt_sel2;
      sel3_ff <= nxt_sel3;
      four_d_ff <= four_s;
      pair_d_ff <= pair_s;
      var_meta_ff <= two_hand_two_contact;
      var_ff <= var_meta_ff;
    end
  end

  // Timer element, no interference evaluation
  thse_timer_element #(.WINDOW_CYC(WINDOW_CYC)) u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .two_hand_change_detect(chg),
    .two_hand_released_pattern(rel),
    .two_hand_actuated_pattern(act),
    .element_output(th_out)
  ); // R7
  assign two_hand_out = th_out;
  assign selector_two_position = sel2_ff;
  assign selector_three_position = sel3_ff;

  // Selector outputs never overlap
  property p_sel3_onehot;
    @(posedge clk_sys) disable iff (reset) $onehot0(sel3_ff);
  endproperty
  a_sel3_onehot: assert property (p_sel3_onehot) else $error("selector overlap"); // R11
  property p_sel2;
    @(posedge clk_sys) disable iff (reset)
      sel2_ff[1] |-> $past(sync2_ff[4:3]) == 2'h2;
  endproperty
  a_sel2: assert property (p_sel2) else $error("selector one wrong"); // R8
  property p_sel3_one;
    @(posedge clk_sys) disable iff (reset) sel3_ff.pos_1 |-> $past(sync2_ff[2:0]) == 3'h4;
  endproperty
  a_sel3_one: assert property (p_sel3_one) else $error("position one wrong"); // R9
  property p_sel3_two;
    @(posedge clk_sys) disable iff (reset) sel3_ff.pos_2 |-> $past(sync2_ff[2:0]) == 3'h2;
  endproperty
  a_sel3_two: assert property (p_sel3_two) else $error("position two wrong"); // R10
  c_sel: cover property (@(posedge clk_sys) sel3_ff.pos_3);
endmodule : thse_eval

// *** rtl/thse_timer_element.sv ***
`timescale 1ns/100ps
`include "thse_consts.svh"
// Two-hand timer element: change detect, released and actuated patterns
module thse_timer_element
  import thse_pkg::*;
#(
  parameter int WINDOW_CYC = `THSE_WINDOW_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pattern inputs
  input wire logic two_hand_change_detect,
  input wire logic two_hand_released_pattern,
  input wire logic two_hand_actuated_pattern,
  // Result
  output logic element_output
);
  localparam int CW = $clog2(WINDOW_CYC + 1);
  // State and window counter
  thse_state_type state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic out_ff, nxt_out;

  // Next state
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      THSE_IDLE: begin
        nxt_cnt = '0;
        // First press starts a fresh window
        if (two_hand_actuated_pattern) begin
          nxt_state = THSE_ON;
        end else if (two_hand_change_detect && !two_hand_released_pattern) begin
          nxt_state = THSE_WAIT; // R2 R6
        end
      end
      THSE_WAIT: begin
        nxt_cnt = cnt_ff + 1'b1;
        if (two_hand_actuated_pattern) begin
          nxt_state = THSE_ON; // R3
        end else if (two_hand_released_pattern) begin
          nxt_state = THSE_IDLE; // R4 R7
        end else if (cnt_ff >= CW'(WINDOW_CYC - 1)) begin
          nxt_state = THSE_FAULT; // R2 R6
        end
      end
      THSE_ON: begin
        // Any release drops at once, no time limit
        if (!two_hand_actuated_pattern) begin
          nxt_state = two_hand_released_pattern ? THSE_IDLE : THSE_FAULT; // R7 R12
        end
      end
      THSE_FAULT: begin
        // Held off until full release
        if (two_hand_released_pattern) begin
          nxt_state = THSE_IDLE; // R12
        end
      end
      default: nxt_state = THSE_IDLE;
    endcase
    nxt_out = (nxt_state == THSE_ON);
  end

  // Registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_ff <= THSE_IDLE;
      cnt_ff <= '0;
      out_ff <= `THSE_OUT_RST;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end
  assign element_output = out_ff;

  // Fault blocks output until release
  property p_fault_hold;
    @(posedge clk_sys) disable iff (reset)
      (state_ff == THSE_FAULT && !two_hand_released_pattern) |=> !out_ff;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("output during fault"); // R12
  // Output only while actuated pattern held
  property p_out_cause;
    @(posedge clk_sys) disable iff (reset)
      out_ff |-> $past(two_hand_actuated_pattern);
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("output without actuation"); // R3
  // Window overrun leads to fault
  property p_timeout;
    @(posedge clk_sys) disable iff (reset)
      (state_ff == THSE_WAIT && cnt_ff == CW'(WINDOW_CYC - 1) && !two_hand_actuated_pattern
       && !two_hand_released_pattern) |=> state_ff == THSE_FAULT;
  endproperty
  a_timeout: assert property (p_timeout) else $error("window not enforced"); // R2
  // Release returns to idle with no limit
  property p_release;
    @(posedge clk_sys) disable iff (reset)
      (state_ff != THSE_IDLE && two_hand_released_pattern) |=> state_ff == THSE_IDLE;
  endproperty
  a_release: assert property (p_release) else $error("release not accepted"); // R7
  c_on: cover property (@(posedge clk_sys) state_ff == THSE_WAIT ##1 state_ff == THSE_ON);
  c_fault: cover property (@(posedge clk_sys) state_ff == THSE_WAIT ##1 state_ff == THSE_FAULT);
  c_rel: cover property (@(posedge clk_sys) state_ff == THSE_FAULT ##1 state_ff == THSE_IDLE);
endmodule : thse_timer_element

// *** sim/tb_two_hand_and_selector_eval.sv ***
`timescale 1ns/100ps
// Self-checking bench for the two-hand and selector evaluation
module tb_two_hand_and_selector_eval;
  import thse_pkg::*;
  localparam int WIN = 20; // Short window for simulation
  logic clk_sys = 1'b0; // System clock
  logic reset = 1'b1; // Sync reset
  logic strap = 1'b0; // Variant select
  thse_four_type four = 4'ha; // Four-contact command
  logic [1:0] pair = 2'h0; // Two-contact command
  logic [1:0] sel2 = 2'h0; // Two-position command
  logic [2:0] sel3 = 3'h0; // Three-position command
  thse_four_type four_pins; // Pins
  logic [1:0] pair_pins, sel2_pins, sel2_out;
  logic [2:0] sel3_pins;
  logic th_out; // Two-hand result
  thse_sel_type sel3_out; // Three-position result
  int err_count = 0;
  int cmp_count = 0;
  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;
  thse_switch_model PART (.want_four(four), .want_pair(pair), .want_sel2(sel2),
    .want_sel3(sel3), .four_pins(four_pins), .pair_pins(pair_pins),
    .sel2_pins(sel2_pins), .sel3_pins(sel3_pins));
  thse_eval #(.WINDOW_CYC(WIN)) DUT (.clk_sys(clk_sys), .reset(reset),
    .two_hand_two_contact(strap), .four_pins(four_pins), .pair_pins(pair_pins),
    .sel2_pins(sel2_pins), .sel3_pins(sel3_pins), .two_hand_out(th_out),
    .selector_two_position(sel2_out), .selector_three_position(sel3_out));
  // Wait edges, then step just past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  // Compare one result
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Verdict and end of run
  task automatic test_done();
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  // Every selector pattern
  task automatic t_sel();
    for (int i = 0; i < 4; i++) begin
      sel2 = i[1:0];
      tick(6);
      chk({1'b0, sel2_out}, (i == 1 || i == 2) ? i[2:0] : 3'h0);
    end
    for (int i = 0; i < 8; i++) begin
      sel3 = i[2:0];
      tick(6);
      chk(sel3_out, (i == 1 || i == 2 || i == 4) ? i[2:0] : 3'h0);
    end
  endtask : t_sel
  // Four-contact: in time, late, wrong pattern, re-arm
  task automatic t_four();
    strap = 1'b0;
    tick(8);
    chk({2'h0, th_out}, 3'h0);
    four = 4'h5;
    tick(8);
    chk({2'h0, th_out}, 3'h1);
    four = 4'ha;
    tick(8);
    chk({2'h0, th_out}, 3'h0);
    four = 4'h6;
    tick(WIN / 2);
    four = 4'h5;
    tick(8);
    chk({2'h0, th_out}, 3'h1);
    four = 4'ha;
    tick(8);
    four = 4'h6;
    tick(WIN + 10);
    four = 4'h5;
    tick(8);
    chk({2'h0, th_out}, 3'h0);
    four = 4'ha;
    tick(8);
    four = 4'h7;
    tick(8);
    chk({2'h0, th_out}, 3'h0);
    four = 4'h5;
    tick(8);
    chk({2'h0, th_out}, 3'h1);
    four = 4'ha;
    tick(8);
  endtask : t_four
  // Two-contact: one hand, both in time, late, re-arm
  task automatic t_pair();
    strap = 1'b1;
    tick(6);
    pair = 2'h2;
    tick(8);
    chk({2'h0, th_out}, 3'h0);
    pair = 2'h3;
    tick(8);
    chk({2'h0, th_out}, 3'h1);
    pair = 2'h0;
    tick(8);
    chk({2'h0, th_out}, 3'h0);
    pair = 2'h1;
    tick(WIN + 10);
    pair = 2'h3;
    tick(8);
    chk({2'h0, th_out}, 3'h0);
    pair = 2'h0;
    tick(8);
    pair = 2'h3;
    tick(8);
    chk({2'h0, th_out}, 3'h1);
  endtask : t_pair
  // Main sequence
  initial begin
    tick(10);
    reset = 1'b0;
    tick(2);
    chk({th_out, sel2_out}, 3'h0);
    t_sel();
    t_four();
    t_pair();
    test_done();
  end
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
endmodule : tb_two_hand_and_selector_eval

// *** sim/thse_switch_model.sv ***
`timescale 1ns/100ps
// Pushbutton and selector contacts; pins follow the commanded contact state
module thse_switch_model
  import thse_pkg::*;
(
  // Commanded contact states
  input wire thse_four_type want_four,
  input wire logic [1:0] want_pair,
  input wire logic [1:0] want_sel2,
  input wire logic [2:0] want_sel3,
  // Contact pins
  output thse_four_type four_pins,
  output logic [1:0] pair_pins,
  output logic [1:0] sel2_pins,
  output logic [2:0] sel3_pins
);
  // Contacts switch when the operator moves them, with no bounce
  assign four_pins = want_four;
  assign pair_pins = want_pair;
  assign sel2_pins = want_sel2;
  assign sel3_pins = want_sel3;
endmodule : thse_switch_model
